// *** ams_issuer.sv ***
`timescale 1ns/100ps
module ams_issuer (
   input wire logic clk_sys, // Core clock
   input wire logic issue_ready, // Unit takes the offer
   output logic issue_valid, // Offer present
   output logic [ams_pkg::INSTR_W-1:0] issue_instr, // Instruction word
   output logic [ams_pkg::WORD_W-1:0] src_a_val, // src_a contents
   output logic [ams_pkg::WORD_W-1:0] src_b_val // src_b contents
);
   import ams_pkg::*;
   initial begin
      issue_valid = 1'b0;
      issue_instr = '0;
      src_a_val = '0;
      src_b_val = '0;
   end
   // Offer a word and hold it until the edge that takes it
   task automatic issue(input logic [INSTR_W-1:0] ins,
         input logic [WORD_W-1:0] a, b, output bit ok);
      int n;
      bit ms;
      ok = 1'b0;
      ms = (ins[OP_MSB:OP_LSB] == OPC_GROUP_TWO);
      issue_valid = 1'b1;
      issue_instr = ins;
      src_a_val = ms ? {{32{a[31]}}, a[31:0]} : a;
      src_b_val = ms ? {{32{b[31]}}, b[31:0]} : b;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge clk_sys);
         ok = (issue_ready === 1'b1);
      end
      #1;
   endtask
   // Released lines show a changing pattern, not the old value
   task automatic idle();
      issue_valid = 1'b0;
      issue_instr = ~issue_instr;
      src_a_val = ~src_a_val;
      src_b_val = ~src_b_val;
      @(posedge clk_sys);
      #1;
   endtask
endmodule

// *** ams_pkg.sv ***
package ams_pkg;

   // ********************************************************************
   // Widths
   // ********************************************************************
   localparam int WORD_W = 64;
   localparam int ACC_W = 128;
   localparam int NUM_ACC = 4;
   localparam int INSTR_W = 32;
   localparam int REG_ADDR_W = 5;
   localparam int SEL_W = 2;

   // ********************************************************************
   // Instruction fields
   // ********************************************************************
   localparam int OP_MSB = 31;
   localparam int OP_LSB = 26;
   localparam int FN_MSB = 5;
   localparam int FN_LSB = 0;
   localparam int SUB_MSB = 10;
   localparam int SUB_LSB = 6;
   localparam int SRC_A_MSB = 25;
   localparam int SRC_A_LSB = 21;
   localparam int SRC_B_MSB = 20;
   localparam int SRC_B_LSB = 16;
   localparam int DST_MSB = 15;
   localparam int DST_LSB = 11;
   // Index decrement fields of src_b
   localparam int TOP_IDX_MSB = 23;
   localparam int TOP_IDX_LSB = 8;
   localparam int DECR_MSB = 7;
   // Accumulator select of the move-from forms
   localparam int MV_SEL_MSB = 22;
   localparam int MV_SEL_LSB = 21;
   localparam int MV_ZERO_MSB = 25;
   localparam int MV_ZERO_LSB = 23;
   // Accumulator select of the multiply-subtract forms
   localparam int MS_SEL_MSB = 12;
   localparam int MS_SEL_LSB = 11;
   localparam int MS_ZERO_MSB = 15;
   localparam int MS_ZERO_LSB = 13;

   // ********************************************************************
   // Encodings
   // ********************************************************************
   localparam logic [5:0] OPC_BASE = 6'h00;
   localparam logic [5:0] OPC_GROUP_TWO = 6'h1c;
   localparam logic [5:0] OPC_GROUP_THREE = 6'h1f;
   localparam logic [5:0] FN_READ_UPPER = 6'h10;
   localparam logic [5:0] FN_READ_BOTTOM = 6'h12;
   localparam logic [5:0] FN_INDEX_GROUP = 6'h10;
   localparam logic [4:0] SUB_INDEX_DEC = 5'h12;
   localparam logic [5:0] FN_SIGNED_SIGNED_MUL_SUBTRACT = 6'h04;
   localparam logic [5:0] FN_UNSIGNED_SIGNED_MUL_SUBTRACT = 6'h05;

   // ********************************************************************
   // Timing and reset values
   // ********************************************************************
   // Cycles from taking a multiply-subtract to the accumulator write
   localparam int MUL_LAT = 4;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(MUL_LAT - 2);
   localparam logic [ACC_W-1:0] ACC_RST = 128'h0;

endpackage

// *** ams_unit.sv ***
`timescale 1ns/100ps
// Contract
// - Read-upper copies accumulator bits 127..64 to the destination.
// - Read-bottom copies accumulator bits 63..0 to the destination.
// - Two-bit select picks one of four accumulators; zero is the original.
// - Read-upper decodes from opcode 000000, function 010000, zero fields.
// - Read-bottom decodes from opcode 000000, function 010010.
// - Index decrement decodes opcode 011111, function 010000, sub 10010.
// - Zero low word of src_a: write src_b bits 23..8 zero-extended.
// - Otherwise write src_a minus unsigned element size in src_b bits 7..0.
// - Index decrement never touches the overflow flags.
// - Signed multiply-subtract decodes opcode 011100, function 000100.
// - Signed 32x32 product is subtracted from the 64-bit accumulator value.
// - Unsigned multiply-subtract decodes opcode 011100, function 000101.
// - Unsigned 32x32 product is subtracted from the accumulator value.
// - Multiply-subtract never raises an exception; wraps silently.
// - Multiply-subtract writes only the accumulator, no general register.
// - Accumulator reads stall until a pending multiply result is written.
module ams_unit (
   input wire logic clk_sys, // Core clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic issue_valid, // Decoded instruction offered
   input wire logic [ams_pkg::INSTR_W-1:0] issue_instr, // Instruction word
   input wire logic [ams_pkg::WORD_W-1:0] src_a_val, // src_a contents
   input wire logic [ams_pkg::WORD_W-1:0] src_b_val, // src_b contents
   output logic issue_ready, // Unit can take an instruction
   output logic gpr_wr_en, // General register write pulse
   output logic [ams_pkg::REG_ADDR_W-1:0] gpr_wr_addr, // Destination
   output logic [ams_pkg::WORD_W-1:0] gpr_wr_data, // Destination value
   output logic acc_wr_en, // Accumulator write pulse
   output logic [ams_pkg::SEL_W-1:0] acc_wr_idx, // Accumulator written
   output logic [ams_pkg::ACC_W-1:0] acc_wr_data, // Value written
   output logic reserved_instr, // Undecoded instruction pulse
   output logic ouflag_wr_en // Overflow flag update, never raised
);
   import ams_pkg::*;

   // ********************************************************************
   // State
   // ********************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_MUL = 2'b10
   } ams_state_t;

   typedef struct packed {
      ams_state_t state;
      logic [NUM_ACC-1:0][ACC_W-1:0] acc;
      logic [SEL_W-1:0] pend_idx;
      logic [WORD_W-1:0] pend_diff;
      logic [CNT_W-1:0] cnt;
      logic ready;
      logic gpr_wr_en;
      logic [REG_ADDR_W-1:0] gpr_wr_addr;
      logic [WORD_W-1:0] gpr_wr_data;
      logic acc_wr_en;
      logic [SEL_W-1:0] acc_wr_idx;
      logic [ACC_W-1:0] acc_wr_data;
      logic rsv;
      logic flag_wr;
   } ams_regs_t;

   ams_regs_t st_r;
   ams_regs_t st_nxt;

   // ********************************************************************
   // Decode
   // ********************************************************************
   logic [5:0] opc;
   logic [5:0] fn;
   logic [4:0] sub;
   logic [SEL_W-1:0] mv_sel;
   logic [SEL_W-1:0] ms_sel;
   logic [REG_ADDR_W-1:0] dst;
   logic is_upper;
   logic is_bottom;
   logic is_index_dec;
   logic is_smsub;
   logic is_umsub;
   logic take;

   assign opc = issue_instr[OP_MSB:OP_LSB];
   assign fn = issue_instr[FN_MSB:FN_LSB];
   assign sub = issue_instr[SUB_MSB:SUB_LSB];
   assign mv_sel = issue_instr[MV_SEL_MSB:MV_SEL_LSB];
   assign ms_sel = issue_instr[MS_SEL_MSB:MS_SEL_LSB];
   assign dst = issue_instr[DST_MSB:DST_LSB];

   // Move-from forms: zero fields above select, src_b slot and shift slot
   logic mv_zero;
   logic ms_zero;
   assign mv_zero = (issue_instr[MV_ZERO_MSB:MV_ZERO_LSB] == 3'h0)
      && (issue_instr[SRC_B_MSB:SRC_B_LSB] == 5'h00) && (sub == 5'h00);
   assign ms_zero = (issue_instr[MS_ZERO_MSB:MS_ZERO_LSB] == 3'h0)
      && (sub == 5'h00);

   assign is_upper = (opc == OPC_BASE) && (fn == FN_READ_UPPER)
      && mv_zero;
   assign is_bottom = (opc == OPC_BASE) && (fn == FN_READ_BOTTOM)
      && mv_zero;
   assign is_index_dec = (opc == OPC_GROUP_THREE)
      && (fn == FN_INDEX_GROUP) && (sub == SUB_INDEX_DEC);
   assign is_smsub = (opc == OPC_GROUP_TWO) && (fn == FN_SIGNED_SIGNED_MUL_SUBTRACT)
      && ms_zero;
   assign is_umsub = (opc == OPC_GROUP_TWO) && (fn == FN_UNSIGNED_SIGNED_MUL_SUBTRACT)
      && ms_zero;

   // Reads of the accumulators are refused while a product is pending
   assign take = issue_valid && st_r.ready;

   // ********************************************************************
   // Datapath
   // ********************************************************************
   logic [WORD_W-1:0] rd_upper;
   logic [WORD_W-1:0] rd_bottom;
   logic [WORD_W-1:0] idx_wrap;
   logic [WORD_W-1:0] idx_dec;
   logic [15:0] b_top;
   logic [WORD_W-1:0] acc_start;
   logic signed [WORD_W-1:0] prod_s;
   logic [WORD_W-1:0] prod_u;
   logic [WORD_W-1:0] diff;

   assign rd_upper = st_r.acc[mv_sel][ACC_W-1:WORD_W];
   assign rd_bottom = st_r.acc[mv_sel][WORD_W-1:0];
   // Index fields of src_b: top index and element size
   assign b_top = src_b_val[TOP_IDX_MSB:TOP_IDX_LSB];
   assign idx_wrap = {48'h0, b_top};
   assign idx_dec = src_a_val - {56'h0, src_b_val[DECR_MSB:0]};

   // Only the low word of each half forms the starting value
   assign acc_start = {st_r.acc[ms_sel][95:64],
                       st_r.acc[ms_sel][31:0]};
   // Only the low source words enter the product
   assign prod_s = $signed({{32{src_a_val[31]}}, src_a_val[31:0]})
      * $signed({{32{src_b_val[31]}}, src_b_val[31:0]});
   assign prod_u = {32'h0, src_a_val[31:0]}
      * {32'h0, src_b_val[31:0]};
   // Plain modular subtraction, no overflow detection
   assign diff = acc_start
      - (is_smsub ? WORD_W'(prod_s) : prod_u);

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.gpr_wr_en = 1'b0;
      st_nxt.acc_wr_en = 1'b0;
      st_nxt.rsv = 1'b0;
      st_nxt.flag_wr = 1'b0;
      unique case (st_r.state)
         ST_IDLE: begin
            if (take) begin
               if (is_upper) begin
                  st_nxt.gpr_wr_en = 1'b1;
                  st_nxt.gpr_wr_addr = dst;
                  st_nxt.gpr_wr_data = rd_upper;
               end else if (is_bottom) begin
                  st_nxt.gpr_wr_en = 1'b1;
                  st_nxt.gpr_wr_addr = dst;
                  st_nxt.gpr_wr_data = rd_bottom;
               end else if (is_index_dec) begin
                  st_nxt.gpr_wr_en = 1'b1;
                  st_nxt.gpr_wr_addr = dst;
                  if (src_a_val[31:0] == 32'h0) begin
                     st_nxt.gpr_wr_data = idx_wrap;
                  end else begin
                     st_nxt.gpr_wr_data = idx_dec;
                  end
               end else if (is_smsub || is_umsub) begin
                  // No general register write for these
                  st_nxt.pend_idx = ms_sel;
                  st_nxt.pend_diff = diff;
                  st_nxt.cnt = CNT_LOAD;
                  st_nxt.ready = 1'b0;
                  st_nxt.state = ST_MUL;
               end else begin
                  st_nxt.rsv = 1'b1;
               end
            end
         end
         ST_MUL: begin
            if (st_r.cnt == '0) begin
               st_nxt.acc[st_r.pend_idx] =
                  {{32{st_r.pend_diff[63]}}, st_r.pend_diff[63:32],
                   {32{st_r.pend_diff[31]}},
                   st_r.pend_diff[31:0]};
               st_nxt.acc_wr_en = 1'b1;
               st_nxt.acc_wr_idx = st_r.pend_idx;
               st_nxt.acc_wr_data = st_nxt.acc[st_r.pend_idx];
               st_nxt.ready = 1'b1;
               st_nxt.state = ST_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt - CNT_W'(1);
            end
         end
         default: begin
            st_nxt.state = ST_IDLE;
            st_nxt.ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.state <= ST_IDLE;
         st_r.acc <= {NUM_ACC{ACC_RST}};
         st_r.ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign issue_ready = st_r.ready;
   assign gpr_wr_en = st_r.gpr_wr_en;
   assign gpr_wr_addr = st_r.gpr_wr_addr;
   assign gpr_wr_data = st_r.gpr_wr_data;
   assign acc_wr_en = st_r.acc_wr_en;
   assign acc_wr_idx = st_r.acc_wr_idx;
   assign acc_wr_data = st_r.acc_wr_data;
   assign reserved_instr = st_r.rsv;
   assign ouflag_wr_en = st_r.flag_wr;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   localparam int LAT_A = MUL_LAT;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   logic t_upper;
   logic t_bottom;
   logic t_idx;
   logic t_signed_mul_subtract;
   assign t_upper = take && is_upper;
   assign t_bottom = take && is_bottom;
   assign t_idx = take && is_index_dec;
   assign t_signed_mul_subtract = take && (is_smsub || is_umsub);

   read_upper_a: assert property (t_upper |=> gpr_wr_en
      && gpr_wr_data == $past(rd_upper) && gpr_wr_addr == $past(dst))
      else $error("upper half read wrong");
   read_bottom_a: assert property (t_bottom |=> gpr_wr_en
      && gpr_wr_data == $past(rd_bottom) && gpr_wr_addr == $past(dst))
      else $error("bottom half read wrong");
   index_wrap_a: assert property (t_idx && src_a_val[31:0] == 32'h0
      |=> gpr_wr_en && gpr_wr_data == {48'h0, $past(b_top)})
      else $error("index wrap value wrong");
   index_dec_a: assert property (t_idx && src_a_val[31:0] != 32'h0
      |=> gpr_wr_en && gpr_wr_data == $past(idx_dec))
      else $error("index decrement wrong");
   no_flag_write_a: assert property (!ouflag_wr_en)
      else $error("overflow flags touched");
   signed_mul_subtract_latency_a: assert property (t_signed_mul_subtract |-> ##LAT_A acc_wr_en
      && acc_wr_idx == $past(ms_sel, LAT_A))
      else $error("multiply result late or misplaced");
   signed_mul_subtract_no_gpr_a: assert property (t_signed_mul_subtract |=> !gpr_wr_en[*3])
      else $error("multiply-subtract wrote a register");
   read_stall_a: assert property (t_signed_mul_subtract |=> !issue_ready[*3])
      else $error("reads not stalled");
   signed_mul_subtract_value_a: assert property (t_signed_mul_subtract |-> ##LAT_A
      acc_wr_data[95:64] == $past(diff[63:32], LAT_A)
      && acc_wr_data[31:0] == $past(diff[31:0], LAT_A))
      else $error("accumulator difference wrong");
   acc_sext_a: assert property (acc_wr_en |->
      acc_wr_data[127:96] == {32{acc_wr_data[95]}}
      && acc_wr_data[63:32] == {32{acc_wr_data[31]}})
      else $error("accumulator halves not sign-extended");
   no_signed_mul_subtract_trap_a: assert property (t_signed_mul_subtract |=> !reserved_instr)
      else $error("multiply-subtract raised a fault");

   // Interlock, pulse and reserved-word checks
   ready_back_a: assert property (t_signed_mul_subtract |-> ##LAT_A issue_ready)
      else $error("issue not resumed with the result");
   stall_quiet_a: assert property (!issue_ready |=> !gpr_wr_en
      && !reserved_instr)
      else $error("instruction taken during stall");
   rsv_pulse_a: assert property (take && !(is_upper || is_bottom
      || is_index_dec || is_smsub || is_umsub)
      |=> reserved_instr && !gpr_wr_en && !acc_wr_en)
      else $error("undecoded word not flagged");
   signed_mul_subtract_acc_only_a: assert property (t_signed_mul_subtract |-> ##LAT_A acc_wr_en
      && !gpr_wr_en && !reserved_instr)
      else $error("multiply-subtract result on wrong port");
   idx_no_acc_a: assert property (t_idx |=> !acc_wr_en)
      else $error("index decrement touched an accumulator");
   acc_pulse_a: assert property (acc_wr_en |=> !acc_wr_en)
      else $error("accumulator written twice");

   rsv_seen_c: cover property (reserved_instr);
   wrap_seen_c: cover property (t_idx && src_a_val[31:0] == 32'h0);
   smsub_seen_c: cover property (take && is_smsub ##LAT_A acc_wr_en);
   umsub_seen_c: cover property (take && is_umsub ##LAT_A acc_wr_en);
   stall_read_c: cover property (issue_valid && !issue_ready
      ##[1:8] t_upper);

endmodule

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
   import ams_pkg::*;
   typedef struct {
      logic [2:0] kind;
      logic [4:0] addr;
      logic [127:0] data;
   } ams_note_t;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic issue_valid, issue_ready, gpr_wr_en, acc_wr_en;
   logic reserved_instr, ouflag_wr_en;
   logic [INSTR_W-1:0] issue_instr;
   logic [WORD_W-1:0] src_a_val, src_b_val, gpr_wr_data, a, b;
   logic [REG_ADDR_W-1:0] gpr_wr_addr;
   logic [SEL_W-1:0] acc_wr_idx;
   logic [ACC_W-1:0] acc_wr_data;
   logic [127:0] acc_m [4] = '{default: '0};
   ams_note_t notes[$];
   ams_note_t got;
   int num_errors = 0;
   int tests_run = 0;
   int seed = 65;
   int i;
   always #4 clk_sys = ~clk_sys;
   ams_unit u_ams_unit (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .issue_valid(issue_valid), .issue_instr(issue_instr),
      .src_a_val(src_a_val), .src_b_val(src_b_val),
      .issue_ready(issue_ready), .gpr_wr_en(gpr_wr_en),
      .gpr_wr_addr(gpr_wr_addr), .gpr_wr_data(gpr_wr_data),
      .acc_wr_en(acc_wr_en), .acc_wr_idx(acc_wr_idx),
      .acc_wr_data(acc_wr_data), .reserved_instr(reserved_instr),
      .ouflag_wr_en(ouflag_wr_en));
   ams_issuer u_ams_issuer (.clk_sys(clk_sys), .issue_ready(issue_ready),
      .issue_valid(issue_valid), .issue_instr(issue_instr),
      .src_a_val(src_a_val), .src_b_val(src_b_val));
   // ************
   // Helpers
   // ************
   task automatic test_done();
      $display("checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [127:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] mv(logic [5:0] fn, logic [1:0] s,
         logic [4:0] rd);
      return {OPC_BASE, 3'h0, s, 5'h0, rd, 5'h0, fn};
   endfunction
   function automatic logic [31:0] ms(logic [5:0] fn, logic [1:0] s);
      return {OPC_GROUP_TWO, 5'h3, 5'h4, 3'h0, s, 5'h0, fn};
   endfunction
   // Kind: 0 upper, 1 bottom, 2 index, 3 signed, 4 unsigned, 5 reserved
   task automatic send(input logic [31:0] ins, input logic [63:0] x, y,
         input int k);
      ams_note_t n;
      logic [1:0] s;
      logic [63:0] p, d;
      bit ok;
      s = k < 2 ? ins[MV_SEL_MSB:MV_SEL_LSB] : ins[MS_SEL_MSB:MS_SEL_LSB];
      n.addr = ins[DST_MSB:DST_LSB];
      n.kind = 3'b100;
      n.data = '0;
      case (k)
         0: n.data = {64'h0, acc_m[s][127:64]};
         1: n.data = {64'h0, acc_m[s][63:0]};
         2: n.data = x[31:0] == 32'h0 ? {112'h0, y[23:8]}
               : {64'h0, x - {56'h0, y[7:0]}};
         3, 4: begin
            p = k == 3 ? {{32{x[31]}}, x[31:0]} * {{32{y[31]}}, y[31:0]}
               : {32'h0, x[31:0]} * {32'h0, y[31:0]};
            d = {acc_m[s][95:64], acc_m[s][31:0]} - p;
            n.data = {{32{d[63]}}, d[63:32], {32{d[31]}}, d[31:0]};
            n.kind = 3'b010;
            n.addr = {3'h0, s};
            acc_m[s] = n.data;
         end
         default: n.kind = 3'b001;
      endcase
      notes.push_back(n);
      u_ams_issuer.issue(ins, x, y, ok);
      if (!ok) begin
         num_errors++;
         $display("unexpected stall: expected take seen none");
         test_done();
      end
   endtask
   task automatic drain(input string name);
      int n;
      u_ams_issuer.idle();
      for (n = 0; n < 50 && notes.size() != 0; n++) @(posedge clk_sys);
      if (notes.size() != 0) begin
         num_errors++;
         $display("unexpected missing result: expected %0d seen 0",
            notes.size());
         test_done();
      end
      $display("test %s done", name);
   endtask
   // Result watcher, one note per result pulse
   always @(posedge clk_sys) begin
      #2;
      if (ouflag_wr_en !== 1'b0) check("ouflag", ouflag_wr_en, 0);
      if ({gpr_wr_en, acc_wr_en, reserved_instr} !== 3'b000) begin
         if (notes.size() == 0) check("spurious", 1, 0);
         else begin
            got = notes.pop_front();
            check("kind", {gpr_wr_en, acc_wr_en, reserved_instr},
               got.kind);
            if (got.kind[2]) check("addr", gpr_wr_addr, got.addr);
            if (got.kind[2]) check("gpr", gpr_wr_data, got.data);
            if (got.kind[1]) check("idx", acc_wr_idx, got.addr);
            if (got.kind[1]) check("acc", acc_wr_data, got.data);
            if (got.kind[1]) check("ready", issue_ready, 1);
         end
      end
   end
   // ************
   // Scenarios
   // ************
   initial begin
      repeat (12) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      for (i = 0; i < 8; i++)
         send(mv(i[0] ? FN_READ_BOTTOM : FN_READ_UPPER, i[2:1], 5'(i)),
            0, 0, i % 2);
      drain("reset reads");
      for (i = 0; i < 16; i++) begin
         a = {$random(seed), $random(seed)};
         b = 64'($signed($random(seed) % 40000));
         if (($random(seed) & 1) != 0) u_ams_issuer.idle();
         send(ms(i[0] ? FN_UNSIGNED_SIGNED_MUL_SUBTRACT : FN_SIGNED_SIGNED_MUL_SUBTRACT, i[2:1]), a, b,
            3 + i % 2);
         send(mv(FN_READ_UPPER, i[2:1], 5'h7), 0, 0, 0);
         send(mv(FN_READ_BOTTOM, i[2:1], 5'h8), 0, 0, 1);
      end
      drain("multiply subtract");
      for (i = 0; i < 10; i++) begin
         b = {$random(seed), $random(seed)};
         a = i == 0 ? 64'hffff_ffff_0000_0000 : i == 1 ? 64'h1
            : {$random(seed), $random(seed)};
         send({OPC_GROUP_THREE, 5'h1, 5'h2, 5'(i), SUB_INDEX_DEC,
            FN_INDEX_GROUP}, a, i == 1 ? {b[63:8], 8'h08} : b, 2);
      end
      drain("index decrement");
      send(mv(FN_READ_UPPER, 2'h1, 5'h1) | 32'h0001_0000, 0, 0, 5);
      send(ms(FN_SIGNED_SIGNED_MUL_SUBTRACT, 2'h1) | 32'h0000_0040, 5, 7, 5);
      send({6'h3f, 26'h0}, 0, 0, 5);
      send(mv(FN_READ_UPPER, 2'h1, 5'h2), 0, 0, 0);
      send(mv(FN_READ_BOTTOM, 2'h1, 5'h3), 0, 0, 1);
      drain("reserved words");
      test_done();
   end
endmodule
